/* File: chan_cal_pkg.sv */
package chan_cal_pkg;

  // register indices, not byte offsets; byte address is four times index
  localparam logic [7:0] IDX_CHAN6_CONFIG          = 8'h27;
  localparam logic [7:0] IDX_CHAN6_OFFSET_CAL_HIGH = 8'h28;
  localparam logic [7:0] IDX_CHAN6_OFFSET_CAL_LOW  = 8'h29;
  localparam logic [7:0] IDX_CHAN6_GAIN_CAL_HIGH   = 8'h2A;
  localparam logic [7:0] IDX_CHAN6_GAIN_CAL_LOW    = 8'h2B;
  localparam logic [7:0] IDX_CHAN7_CONFIG          = 8'h2C;

  // reset values
  localparam logic [15:0] RST_CONFIG      = 16'h0000;
  localparam logic [15:0] RST_OFFSET_HIGH = 16'h0000;
  localparam logic [7:0]  RST_OFFSET_LOW  = 8'h00;
  localparam logic [15:0] RST_GAIN_HIGH   = 16'h8000;
  localparam logic [7:0]  RST_GAIN_LOW    = 8'h00;

  // config and calibration-low field positions
  localparam int PHASE_LSB = 6;
  localparam int DCOFF_BIT = 2;
  localparam int CAL_LOW_LSB = 8;

  // input selection codes
  typedef enum logic [1:0] {
    SEL_OWN_PINS  = 2'b00,
    SEL_SHORTED   = 2'b01,
    SEL_TEST_POS  = 2'b10,
    SEL_TEST_NEG  = 2'b11
  } input_sel_t;

  // one channel configuration
  typedef struct packed {
    logic [9:0] phase_delay;
    logic       dc_filter_off;
    input_sel_t input_select;
  } chan_cfg_t;

  localparam chan_cfg_t RST_CFG = '{phase_delay: 10'h000, dc_filter_off: 1'b0,
                                    input_select: SEL_OWN_PINS};

endpackage

/* File: chan_cal_regs.sv */
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - config holds 10-bit signed phase delay in 15:6; bits 5:3 read zero
// - config bit 2 set disables dc filter for channel; clear follows global
// - config bits 1:0 select input: own pins, shorted, positive or negative test
// - offset upper sixteen bits in high register, read-write, reset zero
// - offset low byte in upper byte of low register; lower byte reads zero
// - gain upper sixteen bits in high register, reset 8000h for unity gain
// - gain low byte in upper byte of low register; lower byte reads zero
// - offset high/low at 28h/29h, gain high/low at 2Ah/2Bh
// - next channel config at 2Ch, same layout, resets zero
module chan_cal_regs (
  input  wire logic                      mclk,
  input  wire logic                      resetn,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic      [31:0]               hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  output chan_cal_pkg::chan_cfg_t        chan6_cfg,
  output chan_cal_pkg::chan_cfg_t        chan7_cfg,
  output logic      [23:0]               chan6_offset,
  output logic      [23:0]               chan6_gain
);

  ////////////////////////////////////////////////////////////////////////////
  // address phase capture

  logic       wr_pend;
  logic [7:0] wr_idx;
  logic       addr_ok;
  logic [7:0] acc_idx;

  assign acc_idx = haddr[9:2];
  assign addr_ok = hsel && hready && htrans[1] && (haddr[31:10] == 22'h0);

  // latch write address for data phase
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wr_pend <= 1'b0;
      wr_idx  <= 8'h00;
    end else begin
      wr_pend <= addr_ok && hwrite;
      wr_idx  <= acc_idx;
    end
  end

  // zero-wait slave, always okay
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  logic [15:0] wdata;
  assign wdata = hwdata[15:0];

  // channel 6 configuration
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      chan6_cfg <= chan_cal_pkg::RST_CFG;
    end else if (wr_pend && wr_idx == chan_cal_pkg::IDX_CHAN6_CONFIG) begin
      chan6_cfg.phase_delay   <= wdata[15:chan_cal_pkg::PHASE_LSB];
      chan6_cfg.dc_filter_off <= wdata[chan_cal_pkg::DCOFF_BIT];
      chan6_cfg.input_select  <= chan_cal_pkg::input_sel_t'(wdata[1:0]);
    end
  end

  // channel 7 configuration, same layout
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      chan7_cfg <= chan_cal_pkg::RST_CFG;
    end else if (wr_pend && wr_idx == chan_cal_pkg::IDX_CHAN7_CONFIG) begin
      chan7_cfg.phase_delay   <= wdata[15:chan_cal_pkg::PHASE_LSB];
      chan7_cfg.dc_filter_off <= wdata[chan_cal_pkg::DCOFF_BIT];
      chan7_cfg.input_select  <= chan_cal_pkg::input_sel_t'(wdata[1:0]);
    end
  end

  // offset calibration word
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      chan6_offset <= {chan_cal_pkg::RST_OFFSET_HIGH, chan_cal_pkg::RST_OFFSET_LOW};
    end else if (wr_pend && wr_idx == chan_cal_pkg::IDX_CHAN6_OFFSET_CAL_HIGH) begin
      chan6_offset[23:8] <= wdata;
    end else if (wr_pend && wr_idx == chan_cal_pkg::IDX_CHAN6_OFFSET_CAL_LOW) begin
      chan6_offset[7:0] <= wdata[15:chan_cal_pkg::CAL_LOW_LSB];
    end
  end

  // gain calibration word, unity after reset
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      chan6_gain <= {chan_cal_pkg::RST_GAIN_HIGH, chan_cal_pkg::RST_GAIN_LOW};
    end else if (wr_pend && wr_idx == chan_cal_pkg::IDX_CHAN6_GAIN_CAL_HIGH) begin
      chan6_gain[23:8] <= wdata;
    end else if (wr_pend && wr_idx == chan_cal_pkg::IDX_CHAN6_GAIN_CAL_LOW) begin
      chan6_gain[7:0] <= wdata[15:chan_cal_pkg::CAL_LOW_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  logic [15:0] next_rdata;

  // decode; reserved bits and unmapped indices read zero
  always_comb begin
    next_rdata = 16'h0000;
    case (acc_idx)
      chan_cal_pkg::IDX_CHAN6_CONFIG:
        next_rdata = {chan6_cfg.phase_delay, 3'b000, chan6_cfg.dc_filter_off,
                      chan6_cfg.input_select};
      chan_cal_pkg::IDX_CHAN6_OFFSET_CAL_HIGH: next_rdata = chan6_offset[23:8];
      chan_cal_pkg::IDX_CHAN6_OFFSET_CAL_LOW:  next_rdata = {chan6_offset[7:0], 8'h00};
      chan_cal_pkg::IDX_CHAN6_GAIN_CAL_HIGH:   next_rdata = chan6_gain[23:8];
      chan_cal_pkg::IDX_CHAN6_GAIN_CAL_LOW:    next_rdata = {chan6_gain[7:0], 8'h00};
      chan_cal_pkg::IDX_CHAN7_CONFIG:
        next_rdata = {chan7_cfg.phase_delay, 3'b000, chan7_cfg.dc_filter_off,
                      chan7_cfg.input_select};
      default: next_rdata = 16'h0000;
    endcase
  end

  // read data registered into the data phase
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= {16'h0000, next_rdata};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  // read accepted outside reset, so hrdata really loads
  logic rd_take;
  assign rd_take = resetn && addr_ok && !hwrite;

  a_cfg_reserved_zero: assert property (@(posedge mclk) disable iff (!resetn)
    $past(rd_take && acc_idx == chan_cal_pkg::IDX_CHAN6_CONFIG)
    |-> hrdata[5:3] == 3'b000)
    else $error("config reserved bits not zero");

  a_phase_write: assert property (@(posedge mclk) disable iff (!resetn)
    wr_pend && wr_idx == chan_cal_pkg::IDX_CHAN6_CONFIG
    |=> chan6_cfg.phase_delay == $past(hwdata[15:6]))
    else $error("phase delay not stored");

  a_dc_off_write: assert property (@(posedge mclk) disable iff (!resetn)
    wr_pend && wr_idx == chan_cal_pkg::IDX_CHAN6_CONFIG
    |=> chan6_cfg.dc_filter_off == $past(hwdata[2]))
    else $error("dc filter bit not stored");

  a_sel_write: assert property (@(posedge mclk) disable iff (!resetn)
    wr_pend && wr_idx == chan_cal_pkg::IDX_CHAN6_CONFIG
    |=> chan6_cfg.input_select == $past(hwdata[1:0]))
    else $error("input select not stored");

  a_offset_high: assert property (@(posedge mclk) disable iff (!resetn)
    wr_pend && wr_idx == chan_cal_pkg::IDX_CHAN6_OFFSET_CAL_HIGH
    |=> chan6_offset[23:8] == $past(hwdata[15:0]))
    else $error("offset high not stored");

  a_offset_low: assert property (@(posedge mclk) disable iff (!resetn)
    $past(rd_take && acc_idx == chan_cal_pkg::IDX_CHAN6_OFFSET_CAL_LOW)
    |-> hrdata[15:0] == {$past(chan6_offset[7:0]), 8'h00})
    else $error("offset low readback wrong");

  a_gain_reset: assert property (@(posedge mclk)
    $past(!resetn)
    |-> chan6_gain == {chan_cal_pkg::RST_GAIN_HIGH, chan_cal_pkg::RST_GAIN_LOW})
    else $error("gain not unity after reset");

  a_gain_low: assert property (@(posedge mclk) disable iff (!resetn)
    wr_pend && wr_idx == chan_cal_pkg::IDX_CHAN6_GAIN_CAL_LOW
    |=> chan6_gain[7:0] == $past(hwdata[15:8]))
    else $error("gain low not stored");

  a_gain_high_read: assert property (@(posedge mclk) disable iff (!resetn)
    $past(rd_take && acc_idx == chan_cal_pkg::IDX_CHAN6_GAIN_CAL_HIGH)
    |-> hrdata[15:0] == $past(chan6_gain[23:8]))
    else $error("gain high readback wrong");

  a_chan7_write: assert property (@(posedge mclk) disable iff (!resetn)
    wr_pend && wr_idx == chan_cal_pkg::IDX_CHAN7_CONFIG
    |=> chan7_cfg == $past({hwdata[15:6], hwdata[2:0]}))
    else $error("chan7 config not stored");

  a_upper_zero: assert property (@(posedge mclk) disable iff (!resetn)
    hrdata[31:16] == 16'h0000 && hresp == 1'b0)
    else $error("upper read bits not zero");

  a_cfg6_reset: assert property (@(posedge mclk)
    $past(!resetn) |-> chan6_cfg == chan_cal_pkg::RST_CFG)
    else $error("chan6 config not cleared by reset");

  a_cfg7_reset: assert property (@(posedge mclk)
    $past(!resetn) |-> chan7_cfg == chan_cal_pkg::RST_CFG)
    else $error("chan7 config not cleared by reset");

  a_offset_reset: assert property (@(posedge mclk)
    $past(!resetn)
    |-> chan6_offset == {chan_cal_pkg::RST_OFFSET_HIGH, chan_cal_pkg::RST_OFFSET_LOW})
    else $error("offset not cleared by reset");

  a_rdata_reset: assert property (@(posedge mclk)
    $past(!resetn) |-> hrdata == 32'h0000_0000)
    else $error("read data not cleared by reset");

  a_ready_always: assert property (@(posedge mclk) disable iff (!resetn)
    hreadyout == 1'b1)
    else $error("slave inserted a wait state");

  a_offset_low_write: assert property (@(posedge mclk) disable iff (!resetn)
    wr_pend && wr_idx == chan_cal_pkg::IDX_CHAN6_OFFSET_CAL_LOW
    |=> chan6_offset[7:0] == $past(hwdata[15:8]))
    else $error("offset low not stored");

  a_gain_high_write: assert property (@(posedge mclk) disable iff (!resetn)
    wr_pend && wr_idx == chan_cal_pkg::IDX_CHAN6_GAIN_CAL_HIGH
    |=> chan6_gain[23:8] == $past(hwdata[15:0]))
    else $error("gain high not stored");

  a_offset_high_read: assert property (@(posedge mclk) disable iff (!resetn)
    $past(rd_take && acc_idx == chan_cal_pkg::IDX_CHAN6_OFFSET_CAL_HIGH)
    |-> hrdata[15:0] == $past(chan6_offset[23:8]))
    else $error("offset high readback wrong");

  a_gain_low_read: assert property (@(posedge mclk) disable iff (!resetn)
    $past(rd_take && acc_idx == chan_cal_pkg::IDX_CHAN6_GAIN_CAL_LOW)
    |-> hrdata[15:0] == {$past(chan6_gain[7:0]), 8'h00})
    else $error("gain low readback wrong");

  a_cfg6_read: assert property (@(posedge mclk) disable iff (!resetn)
    $past(rd_take && acc_idx == chan_cal_pkg::IDX_CHAN6_CONFIG)
    |-> hrdata[15:6] == $past(chan6_cfg.phase_delay) && hrdata[2:0] == $past(chan6_cfg[2:0]))
    else $error("chan6 config readback wrong");

  a_cfg7_read: assert property (@(posedge mclk) disable iff (!resetn)
    $past(rd_take && acc_idx == chan_cal_pkg::IDX_CHAN7_CONFIG)
    |-> hrdata[15:6] == $past(chan7_cfg.phase_delay) && hrdata[2:0] == $past(chan7_cfg[2:0]))
    else $error("chan7 config readback wrong");

  a_cfg7_reserved: assert property (@(posedge mclk) disable iff (!resetn)
    $past(rd_take && acc_idx == chan_cal_pkg::IDX_CHAN7_CONFIG)
    |-> hrdata[5:3] == 3'b000)
    else $error("chan7 reserved bits not zero");

  a_low_reserved: assert property (@(posedge mclk) disable iff (!resetn)
    $past(rd_take && (acc_idx == chan_cal_pkg::IDX_CHAN6_OFFSET_CAL_LOW
                      || acc_idx == chan_cal_pkg::IDX_CHAN6_GAIN_CAL_LOW))
    |-> hrdata[7:0] == 8'h00)
    else $error("low register reserved byte not zero");

  a_unmapped_read: assert property (@(posedge mclk) disable iff (!resetn)
    $past(rd_take && (acc_idx < chan_cal_pkg::IDX_CHAN6_CONFIG
                      || acc_idx > chan_cal_pkg::IDX_CHAN7_CONFIG))
    |-> hrdata == 32'h0000_0000)
    else $error("unmapped index read not zero");

  a_cfg6_hold: assert property (@(posedge mclk) disable iff (!resetn)
    !(wr_pend && wr_idx == chan_cal_pkg::IDX_CHAN6_CONFIG)
    |=> $stable(chan6_cfg))
    else $error("chan6 config changed without write");

  a_cfg7_hold: assert property (@(posedge mclk) disable iff (!resetn)
    !(wr_pend && wr_idx == chan_cal_pkg::IDX_CHAN7_CONFIG)
    |=> $stable(chan7_cfg))
    else $error("chan7 config changed without write");

  a_offset_hold: assert property (@(posedge mclk) disable iff (!resetn)
    !(wr_pend && (wr_idx == chan_cal_pkg::IDX_CHAN6_OFFSET_CAL_HIGH
                  || wr_idx == chan_cal_pkg::IDX_CHAN6_OFFSET_CAL_LOW))
    |=> $stable(chan6_offset))
    else $error("offset changed without write");

  a_gain_hold: assert property (@(posedge mclk) disable iff (!resetn)
    !(wr_pend && (wr_idx == chan_cal_pkg::IDX_CHAN6_GAIN_CAL_HIGH
                  || wr_idx == chan_cal_pkg::IDX_CHAN6_GAIN_CAL_LOW))
    |=> $stable(chan6_gain))
    else $error("gain changed without write");

  a_rdata_hold: assert property (@(posedge mclk) disable iff (!resetn)
    !(addr_ok && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without read");

  a_write_pend: assert property (@(posedge mclk) disable iff (!resetn)
    addr_ok && hwrite |=> wr_pend)
    else $error("write address phase not taken");

  a_read_no_pend: assert property (@(posedge mclk) disable iff (!resetn)
    addr_ok && !hwrite |=> !wr_pend)
    else $error("read taken as write");

  a_offset_low_split: assert property (@(posedge mclk) disable iff (!resetn)
    wr_pend && wr_idx == chan_cal_pkg::IDX_CHAN6_OFFSET_CAL_LOW
    |=> chan6_offset[23:8] == $past(chan6_offset[23:8]))
    else $error("offset low write touched high part");

  a_gain_low_split: assert property (@(posedge mclk) disable iff (!resetn)
    wr_pend && wr_idx == chan_cal_pkg::IDX_CHAN6_GAIN_CAL_LOW
    |=> chan6_gain[23:8] == $past(chan6_gain[23:8]))
    else $error("gain low write touched high part");

endmodule
`default_nettype wire

/* File: chan_cal_regs_test.sv */
`timescale 1ns/10ps
`default_nettype none
module chan_cal_regs_test;
  typedef struct packed {
    logic [7:0]  idx;
    logic [31:0] wd;
    logic [31:0] exp;
  } row_t;
  logic                    mclk = 1'b0;
  logic                    resetn = 1'b0;
  logic [31:0]             haddr = 32'h0;
  logic [1:0]              htrans = 2'h0;
  logic                    hwrite = 1'b0;
  logic [31:0]             hwdata = 32'h0;
  logic [31:0]             hrdata;
  logic                    hready;
  logic                    hresp;
  chan_cal_pkg::chan_cfg_t chan6_cfg;
  chan_cal_pkg::chan_cfg_t chan7_cfg;
  logic [23:0]             chan6_offset;
  logic [23:0]             chan6_gain;
  logic [31:0]             rd;
  int                      n_errors = 0;
  int                      n_compared = 0;
  // write value, then expected readback, per register
  row_t rows [10] = '{
    '{8'h27, 32'hFFFF_FFFF, 32'h0000_FFC7},
    '{8'h27, 32'h0000_0004, 32'h0000_0004},
    '{8'h27, 32'h0000_0001, 32'h0000_0001},
    '{8'h27, 32'h0000_0002, 32'h0000_0002},
    '{8'h27, 32'h0000_8003, 32'h0000_8003},
    '{8'h28, 32'hFFFF_A5C3, 32'h0000_A5C3},
    '{8'h29, 32'hFFFF_FFFF, 32'h0000_FF00},
    '{8'h2A, 32'h0000_1234, 32'h0000_1234},
    '{8'h2B, 32'hFFFF_FFFF, 32'h0000_FF00},
    '{8'h2C, 32'hFFFF_FFFF, 32'h0000_FFC7}
  };

  // free-running bus clock
  always #25 mclk = ~mclk;

  chan_cal_regs u_chan_cal_regs (
    .mclk         (mclk),
    .resetn       (resetn),
    .hsel         (1'b1),
    .haddr        (haddr),
    .htrans       (htrans),
    .hwrite       (hwrite),
    .hsize        (3'h2),
    .hwdata       (hwdata),
    .hready       (hready),
    .hrdata       (hrdata),
    .hreadyout    (hready),
    .hresp        (hresp),
    .chan6_cfg    (chan6_cfg),
    .chan7_cfg    (chan7_cfg),
    .chan6_offset (chan6_offset),
    .chan6_gain   (chan6_gain)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // next rising edge with ready high, bounded
  task automatic wait_ready;
    int i;
    i = 0;
    @(posedge mclk);
    while (hready !== 1'b1 && i < 50) begin
      i++;
      @(posedge mclk);
    end
    if (i >= 50) begin
      n_errors++;
      stop_test;
    end
  endtask

  // one single word transfer, address phase then data phase
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] q);
    htrans <= 2'b10;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= w;
    wait_ready;
    htrans <= 2'b00;
    hwdata <= w ? wd : 32'h0;
    wait_ready;
    q = hrdata;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    foreach (rows[i]) begin
      xfer(1'b1, rows[i].idx, rows[i].wd, rd);
      xfer(1'b0, rows[i].idx, 32'h0, rd);
      check(rd, rows[i].exp);
      check({31'h0, hresp}, 32'h0);
    end
    // outputs after the last rows
    check({19'h0, chan6_cfg}, 32'h1003);
    check({19'h0, chan7_cfg}, 32'h1FFF);
    check({8'h0, chan6_offset}, 32'hA5C3FF);
    check({8'h0, chan6_gain}, 32'h1234FF);
    // unmapped index ignores write and reads zero
    xfer(1'b1, 8'h30, 32'hFFFF_FFFF, rd);
    xfer(1'b0, 8'h30, 32'h0, rd);
    check(rd, 32'h0);
    // mid-run reset restores every register
    resetn <= 1'b0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    for (int k = 8'h27; k <= 8'h2C; k++) begin
      xfer(1'b0, k[7:0], 32'h0, rd);
      check(rd, (k == 8'h2A) ? 32'h8000 : 32'h0);
    end
    check({8'h0, chan6_gain}, 32'h800000);
    check({19'h0, chan6_cfg}, 32'h0);
    stop_test;
  end
endmodule
`default_nettype wire
